// ---- bench/ftc_ctrl_tb.sv ----
// ftc_ctrl_tb: self-checking bench for the transceiver control block
// assumes ftc_pkg, ftc_fifo, ftc_ctrl and ftc_proto_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ftc_ctrl_tb
	import ftc_pkg::*;
;
	// ==========================================================
	// shortened counts keep the run brief; expectations derive from them
	localparam int FN = 12;
	localparam int TS = 200;
	logic                  clk = 1'b0, reset_n = 1'b0, txIn, rxOut;
	logic [1:0]            modeSel = MODE_FULL;
	logic                  supplyLow = 1'b0, overTemp = 1'b0, statusRead = 1'b0;
	logic                  diffDominant = 1'b0, highDominant = 1'b0, lowDominant = 1'b0;
	logic [NUM_FAULTS-1:0] faultRaw = 8'h00, faultMask = 8'h00, evData;
	logic                  highDriverEn, lowDriverEn, highTermEn, lowTermEn;
	logic                  receiverEn, wakeDetectEn, irq, txStuck, evValid, evDropped;
	logic                  evReady = 1'b1;
	logic [STAT_HALF-1:0]  busErrorStatusHigh, busErrorStatusLow;
	logic [15:0]           seed = 16'h0316;    // lfsr state
	logic [7:0]            q[$];               // expected event bitmaps
	int                    errors = 0, cmp_count = 0, idx;
	logic                  dh, lw;             // high wire dead, low wire fault
	int                    fl[4] = '{2, 3, 5, 6};
	always #2.5 clk = ~clk;
	ftc_proto_model ftc_proto_model_inst (.clk(clk), .reset_n(reset_n), .txIn(txIn),
		.rxOut(rxOut));
	ftc_ctrl #(.F3_DET(FN), .F6_DET(FN), .F3_REC(FN), .F6_REC(FN), .F47_TOUT(FN),
		.F478_REC(FN), .TX_STUCK(TS)) ftc_ctrl_inst (.clk(clk), .reset_n(reset_n),
		.txIn(txIn), .rxOut(rxOut), .modeSel(modeSel), .supplyLow(supplyLow),
		.overTemp(overTemp), .diffDominant(diffDominant), .highDominant(highDominant),
		.lowDominant(lowDominant), .faultRaw(faultRaw), .highDriverEn(highDriverEn),
		.lowDriverEn(lowDriverEn), .highTermEn(highTermEn), .lowTermEn(lowTermEn),
		.receiverEn(receiverEn), .wakeDetectEn(wakeDetectEn),
		.busErrorStatusHigh(busErrorStatusHigh), .busErrorStatusLow(busErrorStatusLow),
		.statusRead(statusRead), .faultMask(faultMask), .irq(irq), .txStuck(txStuck),
		.evValid(evValid), .evReady(evReady), .evData(evData), .evDropped(evDropped));
	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic pulse_read();
		tick(1);
		statusRead <= 1'b1;
		tick(1);
		statusRead <= 1'b0;
	endtask : pulse_read
	// transmit dominant briefly and look at both driver enables
	task automatic drv(input logic h, input logic l);
		tick(1);
		ftc_proto_model_inst.send(1'b0);
		tick(2);
		#1;
		check("highDriverEn", highDriverEn, h);
		check("lowDriverEn", lowDriverEn, l);
		tick(1);
		ftc_proto_model_inst.send(1'b1);
	endtask : drv
	// random bus levels, transmit random only when listening; receive checked one edge later
	task automatic rx_sweep(input logic listen);
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			tick(1);
			diffDominant <= seed[0];
			ftc_proto_model_inst.send(seed[1] | ~listen);
			tick(1);
			#1;
			check("rxOut", rxOut, {7'h00, ~(seed[0] | (listen & ~seed[1]))});
		end
	endtask : rx_sweep
	// ==========================================================
	// event monitor: oldest note is taken whenever an event is handed over
	always @(posedge clk) begin
		if (evValid === 1'b1 && evReady === 1'b1) begin
			if (q.size() == 0) begin
				check("unexpected event", evData, 8'h00);
			end else begin
				check("evData", evData, q.pop_front());
			end
		end
	end
	// watchdog: under a thousand cycles expected, cut off well beyond
	initial begin
		#200000;
		errors++;
		complete_run();
	end
	// ==========================================================
	// main sequence
	initial begin
		tick(6);
		#1;
		check("reset outs", {rxOut, highDriverEn, lowDriverEn, highTermEn, lowTermEn, irq,
			evValid}, 8'h4c);
		reset_n <= 1'b1;
		rx_sweep(1'b0);
		tick(1);
		modeSel <= MODE_LISTEN;
		rx_sweep(1'b1);
		drv(1'b0, 1'b0);
		// flags, masks and clear-on-read, one fault at a time
		for (int i = 0; i < NUM_FAULTS; i++) begin
			tick(1);
			faultMask <= i[0] ? (8'h01 << i) : ~(8'h01 << i);
			faultRaw <= 8'h01 << i;
			q.push_back(8'h01 << i);
			pulse_read();
			faultRaw <= 8'h00;
			#1;
			check("status", {busErrorStatusHigh, busErrorStatusLow}, 8'h01 << i);
			check("irq", irq, {7'h00, ~i[0]});
			pulse_read();
			#1;
			check("status cleared", {busErrorStatusHigh, busErrorStatusLow}, 8'h00);
		end
		// filtered single-wire fallback and recovery in both modes
		for (int m = 0; m < 2; m++) begin
			foreach (fl[j]) begin
				idx = fl[j];
				dh = (idx == F3_HIGH_BAT);
				lw = (idx == F4_LOW_GND) || (idx == F7_WIRES_SHORT);
				tick(1);
				modeSel <= m[0] ? MODE_LISTEN : MODE_FULL;
				diffDominant <= lw;
				highDominant <= ~dh & ~lw;
				lowDominant <= dh;
				faultRaw[idx] <= 1'b1;
				q.push_back(8'h01 << idx);
				tick(FN - 3);
				faultRaw[idx] <= 1'b0;
				tick(1);
				faultRaw[idx] <= 1'b1;
				q.push_back(8'h01 << idx);
				tick(FN - 3);
				#1;
				check("rxOut early", rxOut, {7'h00, ~lw});
				tick(6);
				#1;
				check("rxOut single", rxOut, lw);
				check("lowTermEn", lowTermEn, dh);
				check("highTermEn", highTermEn, {7'h00, ~dh});
				if (m == 0) begin
					drv(~dh, dh);
				end
				tick(1);
				faultRaw[idx] <= 1'b0;
				tick(FN + 4);
				#1;
				check("lowTermEn hold", lowTermEn, {7'h00, ~lw});
				tick(1);
				diffDominant <= 1'b0;
				tick(FN + 4);
				#1;
				check("terms back", {highTermEn, lowTermEn, rxOut}, 8'h07);
				pulse_read();
			end
		end
		// stuck dominant transmit, in full mode so the drivers would be on
		tick(1);
		modeSel <= MODE_FULL;
		ftc_proto_model_inst.send(1'b0);
		tick(TS - 4);
		#1;
		check("txStuck early", txStuck, 1'b0);
		tick(8);
		#1;
		check("stuck drivers", {txStuck, highDriverEn, lowDriverEn}, 8'h04);
		tick(1);
		ftc_proto_model_inst.send(1'b1);
		tick(2);
		#1;
		check("txStuck released", txStuck, 1'b0);
		// over-temperature, under-voltage and standby
		tick(1);
		overTemp <= 1'b1;
		drv(1'b0, 1'b0);
		check("receiverEn hot", receiverEn, 1'b1);
		overTemp <= 1'b0;
		supplyLow <= 1'b1;
		drv(1'b0, 1'b0);
		check("supply low", {receiverEn, wakeDetectEn}, 8'h01);
		supplyLow <= 1'b0;
		modeSel <= MODE_STANDBY;
		diffDominant <= 1'b1;
		tick(2);
		#1;
		check("standby", {receiverEn, wakeDetectEn, rxOut}, 8'h03);
		// fill the event buffer with the reader stalled, then drain it
		tick(1);
		evReady <= 1'b0;
		modeSel <= MODE_FULL;    // standby would hide fault 1
		for (int k = 0; k < 10; k++) begin
			tick(1);
			faultRaw[0] <= 1'b1;
			if (k < FIFO_DEPTH) q.push_back(8'h01);
			tick(1);
			faultRaw[0] <= 1'b0;
		end
		tick(2);
		#1;
		check("evDropped", evDropped, 1'b1);
		tick(1);
		evReady <= 1'b1;
		tick(20);
		#1;
		check("events left", q.size(), 8'h00);
		complete_run();
	end
endmodule : ftc_ctrl_tb
`default_nettype wire

// ---- bench/ftc_proto_model.sv ----
// ftc_proto_model: behavioural protocol controller on the transmit and receive pair
// assumes the bench asks for transmit levels through send(); dominant is 0
`timescale 1ns/1ps
`default_nettype none
module ftc_proto_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// transceiver side
	output var logic  txIn,
	input  wire logic rxOut
);
	// ==========================================================
	// transmit and receive
	logic rxSeen_q;    // last sampled receive level, kept for debug
	// recessive until asked otherwise, so reset never sees a stuck line
	initial txIn = 1'b1;
	// level change lands by non-blocking assignment at the caller's edge
	task automatic send(input logic lvl);
		txIn <= lvl;
	endtask : send
	// sample receive on every rising edge, as a real controller would
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxSeen_q <= 1'b1;
		end else begin
			rxSeen_q <= rxOut;
		end
	end
endmodule : ftc_proto_model
`default_nettype wire

// ---- src/ftc_ctrl.sv ----
// ftc_ctrl: digital control of a low-speed fault-tolerant bus transceiver
// assumes comparator and sense inputs already synchronous to clk
// Behaviour
// RL1: no fault: receive follows differential comparison
// RL2: listen-only: transmitter off, receive shows transmit OR bus
// RL3: fault handling same in full and listen modes
// RL4: eight fault types, numbered one to eight
// RL5: faults 3,6 single-wire after detect filter
// RL6: faults 3,6 recover after recovery filter
// RL7: faults 4,7: dominant, then low driver off
// RL8: faults 4,7 recover after recessive filter time
// RL9: transmit automatically on the intact wire
// RL10: latch one flag per fault, two registers
// RL11: masked interrupt when any fault flag set
// RL12: flag stays until read after recovery
// RL13: transmit dominant over 2.0 ms disables drivers
// RL14: over-temperature disables only transmitter stages
// RL15: standby: drivers/receivers off, detect 3,4,7,8
// RL16: supply under-voltage forces standby mode
// RL17: filter times are parameterised cycle counts
// RL18: filter counter restarts when condition drops
`timescale 1ns/1ps
`default_nettype none
module ftc_ctrl
	import ftc_pkg::*;
#(
	parameter int F3_DET     = FILT_DEFAULT,        // fault3_detect_filter
	parameter int F6_DET     = FILT_DEFAULT,        // fault6_detect_filter
	parameter int F3_REC     = FILT_DEFAULT,        // fault3_recover_filter
	parameter int F6_REC     = FILT_DEFAULT,        // fault6_recover_filter
	parameter int F47_TOUT   = FILT_DEFAULT,        // low-wire fault time-out
	parameter int F478_REC   = FILT_DEFAULT,        // low_wire_fault_recover_filter
	parameter int TX_STUCK   = TX_STUCK_CYCLES      // stuck-dominant limit in cycles
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// protocol controller side (dominant = 0)
	input  wire logic                     txIn,
	output logic                          rxOut,
	// mode control
	input  wire logic [1:0]               modeSel,
	input  wire logic                     supplyLow,
	input  wire logic                     overTemp,
	// bus comparators (1 = dominant or fault condition true)
	input  wire logic                     diffDominant,
	input  wire logic                     highDominant,
	input  wire logic                     lowDominant,
	input  wire logic [NUM_FAULTS-1:0]    faultRaw,
	// driver and termination controls
	output logic                          highDriverEn,
	output logic                          lowDriverEn,
	output logic                          highTermEn,
	output logic                          lowTermEn,
	output logic                          receiverEn,
	output logic                          wakeDetectEn,
	// status: flags and interrupt
	output logic [STAT_HALF-1:0]          busErrorStatusHigh,
	output logic [STAT_HALF-1:0]          busErrorStatusLow,
	input  wire logic                     statusRead,
	input  wire logic [NUM_FAULTS-1:0]    faultMask,
	output logic                          irq,
	output logic                          txStuck,
	// fault event stream
	output logic                          evValid,
	input  wire logic                     evReady,
	output logic [NUM_FAULTS-1:0]         evData,
	output logic                          evDropped
);
	// ==========================================================
	// mode decode
	wire ftc_mode_t modeEff = supplyLow ? MODE_STANDBY : ftc_mode_t'(modeSel); // RL16
	wire isStandby = (modeEff == MODE_STANDBY);
	wire isListen  = (modeEff == MODE_LISTEN);
	// standby keeps only 3,4,7,8 watched; full and listen watch all alike
	wire [NUM_FAULTS-1:0] watchMask = isStandby ?             // RL15 RL3
		((NUM_FAULTS'(1) << F3_HIGH_BAT) | (NUM_FAULTS'(1) << F4_LOW_GND) |
		 (NUM_FAULTS'(1) << F7_WIRES_SHORT) | (NUM_FAULTS'(1) << F8_HIGH_5V)) :
		{NUM_FAULTS{1'b1}};
	wire [NUM_FAULTS-1:0] faultSeen = faultRaw & watchMask;    // RL4
	wire lowWireFault = faultSeen[F4_LOW_GND] | faultSeen[F7_WIRES_SHORT];

	// ==========================================================
	// filter counters: fault 3, fault 6, low-wire (4/7) detect and recover
	logic [CNT_W-1:0] f3Cnt_q, f6Cnt_q, f47Cnt_q;
	logic             f3Act_q, f6Act_q, f47Act_q;      // single-wire decisions
	// count target depends on whether we are detecting or recovering
	wire [CNT_W-1:0] f3Lim  = f3Act_q  ? CNT_W'(F3_REC)   : CNT_W'(F3_DET);  // RL17
	wire [CNT_W-1:0] f6Lim  = f6Act_q  ? CNT_W'(F6_REC)   : CNT_W'(F6_DET);
	wire [CNT_W-1:0] f47Lim = f47Act_q ? CNT_W'(F478_REC) : CNT_W'(F47_TOUT);
	// counting condition: fault present when idle, absent when active
	wire f3Run  = f3Act_q  ? !faultSeen[F3_HIGH_BAT] : faultSeen[F3_HIGH_BAT];
	wire f6Run  = f6Act_q  ? !faultSeen[F6_LOW_BAT]  : faultSeen[F6_LOW_BAT];
	// recovery from 4/7 needs the fault gone and the wires recessive
	wire f47Run = f47Act_q ? (!lowWireFault && !diffDominant) : lowWireFault;
	wire f3Hit  = f3Run  && (f3Cnt_q  >= f3Lim  - 1'b1);
	wire f6Hit  = f6Run  && (f6Cnt_q  >= f6Lim  - 1'b1);
	wire f47Hit = f47Run && (f47Cnt_q >= f47Lim - 1'b1);
	// a dropout restarts the count; a completed count flips the decision
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			f3Cnt_q  <= '0;
			f6Cnt_q  <= '0;
			f47Cnt_q <= '0;
			f3Act_q  <= 1'b0;
			f6Act_q  <= 1'b0;
			f47Act_q <= 1'b0;
		end else begin
			f3Cnt_q  <= (f3Run && !f3Hit)   ? f3Cnt_q + 1'b1  : '0;  // RL18 RL5 RL6
			f6Cnt_q  <= (f6Run && !f6Hit)   ? f6Cnt_q + 1'b1  : '0;  // RL18 RL5 RL6
			f47Cnt_q <= (f47Run && !f47Hit) ? f47Cnt_q + 1'b1 : '0;  // RL18 RL7 RL8
			if (f3Hit)  f3Act_q  <= !f3Act_q;   // RL5 RL6
			if (f6Hit)  f6Act_q  <= !f6Act_q;   // RL5 RL6
			if (f47Hit) f47Act_q <= !f47Act_q;  // RL7 RL8
		end
	end

	// ==========================================================
	// transmit stuck-dominant guard
	logic [CNT_W-1:0] txCnt_q;
	logic             txStuck_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txCnt_q   <= '0;
			txStuck_q <= 1'b0;
		end else if (txIn) begin
			// recessive clears the guard: the node may transmit again
			txCnt_q   <= '0;
			txStuck_q <= 1'b0;
		end else if (txCnt_q >= CNT_W'(TX_STUCK)) begin
			txStuck_q <= 1'b1;                  // RL13
		end else begin
			txCnt_q <= txCnt_q + 1'b1;
		end
	end
	assign txStuck = txStuck_q;

	// ==========================================================
	// receive selection and driver control
	// high-wire faults push reception to the low wire, low-wire faults to the high wire
	wire highBad = f3Act_q;
	wire lowBad  = f6Act_q | f47Act_q;
	wire ftc_rxsel_t rxSel = lowBad ? RX_HIGH : (highBad ? RX_LOW : RX_DIFF); // RL1
	wire busDom = (rxSel == RX_HIGH) ? highDominant :
	              (rxSel == RX_LOW)  ? lowDominant  : diffDominant;
	// untimed 4/7 shows as permanent dominant until the time-out flips lowBad
	wire txAllowed = (modeEff == MODE_FULL) && !txStuck_q && !overTemp; // RL13 RL14 RL2
	wire rxDomNext = isStandby ? 1'b0 : (busDom | (isListen & !txIn)); // RL2
	logic rxOut_q, hiDrv_q, loDrv_q, hiTerm_q, loTerm_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxOut_q  <= 1'b1;
			hiDrv_q  <= 1'b0;
			loDrv_q  <= 1'b0;
			hiTerm_q <= 1'b1;
			loTerm_q <= 1'b1;
		end else begin
			rxOut_q  <= !rxDomNext;                         // RL1 RL2
			hiDrv_q  <= txAllowed && !highBad;              // RL9 RL14
			loDrv_q  <= txAllowed && !lowBad;               // RL9 RL7
			hiTerm_q <= !highBad;                           // RL9
			loTerm_q <= !lowBad;                            // RL7
		end
	end
	assign rxOut        = rxOut_q;
	assign highDriverEn = hiDrv_q;
	assign lowDriverEn  = loDrv_q;
	assign highTermEn   = hiTerm_q;
	assign lowTermEn    = loTerm_q;
	assign receiverEn   = !isStandby;   // RL15
	assign wakeDetectEn = isStandby;    // RL15

	// ==========================================================
	// sticky fault flags, cleared by a read only once the fault is gone
	logic [NUM_FAULTS-1:0] flags_q;
	logic [NUM_FAULTS-1:0] faultPrev_q;
	wire  [NUM_FAULTS-1:0] faultRise = faultSeen & ~faultPrev_q;
	generate
		for (genvar i = 0; i < NUM_FAULTS; i++) begin : g_flag
			// set wins over a clear in the same cycle
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					flags_q[i] <= 1'b0;
				end else if (faultSeen[i]) begin
					flags_q[i] <= 1'b1;                  // RL10
				end else if (statusRead) begin
					flags_q[i] <= 1'b0;                  // RL12
				end
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) faultPrev_q <= '0;
		else          faultPrev_q <= faultSeen;
	end
	assign busErrorStatusLow  = flags_q[STAT_HALF-1:0];          // faults 1..4
	assign busErrorStatusHigh = flags_q[NUM_FAULTS-1:STAT_HALF]; // faults 5..8
	assign irq = |(flags_q & ~faultMask);                        // RL11

	// ==========================================================
	// fault onset events buffered for the host; overflow flagged
	logic evDropped_q;
	logic fifoInReady;
	wire  evPush = |faultRise;
	ftc_fifo #(.WIDTH(NUM_FAULTS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.reset_n  (reset_n),
		.inValid  (evPush),
		.inReady  (fifoInReady),
		.inData   (faultRise),
		.outValid (evValid),
		.outReady (evReady),
		.outData  (evData)
	);
	// the flags still hold the fault when the stream backs up
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)                    evDropped_q <= 1'b0;
		else if (evPush && !fifoInReady) evDropped_q <= 1'b1;
	end
	assign evDropped = evDropped_q;

	// ==========================================================
	// checks
	a_listen_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
		isListen |=> !highDriverEn && !lowDriverEn) else $error("driver on in listen"); // RL2
	a_listen_rx_tx: assert property (@(posedge clk) disable iff (!reset_n)
		(isListen && !txIn) |=> !rxOut) else $error("listen rx not dominant"); // RL2
	a_diff_rx: assert property (@(posedge clk) disable iff (!reset_n)
		(modeEff == MODE_FULL && !highBad && !lowBad) |=> rxOut == !$past(diffDominant))
		else $error("rx not differential"); // RL1
	a_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
		faultSeen[0] |=> busErrorStatusLow[0]) else $error("flag not latched"); // RL10
	a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(flags_q[1] && !statusRead) |=> flags_q[1]) else $error("flag lost"); // RL12
	a_irq_mask: assert property (@(posedge clk) disable iff (!reset_n)
		irq == |(flags_q & ~faultMask)) else $error("irq mismatch"); // RL11
	a_stuck_off: assert property (@(posedge clk) disable iff (!reset_n)
		txStuck |=> !highDriverEn && !lowDriverEn) else $error("stuck tx drives"); // RL13
	a_hot_off: assert property (@(posedge clk) disable iff (!reset_n)
		overTemp |=> !highDriverEn && !lowDriverEn) else $error("hot tx drives"); // RL14
	a_uv_standby: assert property (@(posedge clk) disable iff (!reset_n)
		supplyLow |-> !receiverEn && wakeDetectEn) else $error("uv not standby"); // RL16
	a_f3_restart: assert property (@(posedge clk) disable iff (!reset_n)
		(!f3Act_q && !faultSeen[F3_HIGH_BAT]) |=> f3Cnt_q == '0) else $error("f3 no restart"); // RL18

	// ==========================================================
	// further checks on modes, decisions and driver control
	// standby keeps the receive line recessive
	a_standby_rx_idle: assert property (@(posedge clk) disable iff (!reset_n) // RL15
		isStandby |=> rxOut) else $error("standby rx dominant");
	// standby swaps the receiver for wake-up detection
	a_standby_wake: assert property (@(posedge clk) disable iff (!reset_n) // RL15
		isStandby |-> wakeDetectEn && !receiverEn) else $error("standby wake off");
	// full mode always listens
	a_full_rx_on: assert property (@(posedge clk) disable iff (!reset_n) // RL3
		(modeEff == MODE_FULL) |-> receiverEn) else $error("full rx off");
	// listen-only mode always listens
	a_listen_rx_on: assert property (@(posedge clk) disable iff (!reset_n) // RL2
		isListen |-> receiverEn) else $error("listen rx off");
	// high-wire fault drops the high termination
	a_f3_single: assert property (@(posedge clk) disable iff (!reset_n) // RL5
		f3Act_q |=> !highTermEn) else $error("f3 term on");
	// low-wire faults drop the low termination
	a_low_term_off: assert property (@(posedge clk) disable iff (!reset_n) // RL7
		lowBad |=> !lowTermEn) else $error("low term on");
	// low-wire faults stop the low driver
	a_low_drv_off: assert property (@(posedge clk) disable iff (!reset_n) // RL9
		lowBad |=> !lowDriverEn) else $error("low drv on");
	// high-wire fault stops the high driver
	a_high_drv_off: assert property (@(posedge clk) disable iff (!reset_n) // RL9
		highBad |=> !highDriverEn) else $error("high drv on");
	// fault 6 alone also stops the low driver
	a_f6_single: assert property (@(posedge clk) disable iff (!reset_n) // RL5
		f6Act_q |=> !lowDriverEn) else $error("f6 drv on");
	// no fault decision: both terminations stay on
	a_diff_terms: assert property (@(posedge clk) disable iff (!reset_n) // RL1
		(!highBad && !lowBad) |=> highTermEn && lowTermEn) else $error("diff term off");
	// fault 3 decision only after the fault was seen
	a_f3_det_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL5
		$rose(f3Act_q) |-> $past(faultSeen[F3_HIGH_BAT])) else $error("f3 false detect");
	// fault 3 recovery only with the fault gone
	a_f3_rec_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL6
		$fell(f3Act_q) |-> !$past(faultSeen[F3_HIGH_BAT])) else $error("f3 false recover");
	// fault 6 decision only after the fault was seen
	a_f6_det_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL5
		$rose(f6Act_q) |-> $past(faultSeen[F6_LOW_BAT])) else $error("f6 false detect");
	// fault 6 recovery only with the fault gone
	a_f6_rec_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL6
		$fell(f6Act_q) |-> !$past(faultSeen[F6_LOW_BAT])) else $error("f6 false recover");
	// low-wire time-out only while 4 or 7 stands
	a_f47_det_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL7
		$rose(f47Act_q) |-> $past(lowWireFault)) else $error("f47 false detect");
	// low-wire recovery needs recessive wires
	a_f47_rec_quiet: assert property (@(posedge clk) disable iff (!reset_n) // RL8
		$fell(f47Act_q) |-> !$past(diffDominant)) else $error("f47 recover on dom");
	// fault 6 dropout restarts its counter
	a_f6_restart: assert property (@(posedge clk) disable iff (!reset_n) // RL18
		(!f6Act_q && !faultSeen[F6_LOW_BAT]) |=> f6Cnt_q == '0) else $error("f6 no restart");
	// low-wire dropout restarts its counter
	a_f47_restart: assert property (@(posedge clk) disable iff (!reset_n) // RL18
		(!f47Act_q && !lowWireFault) |=> f47Cnt_q == '0) else $error("f47 no restart");
	// stuck flag only rises on a dominant transmit
	a_stuck_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL13
		$rose(txStuck) |-> !$past(txIn)) else $error("stuck without dominant");
	// recessive transmit frees the node again
	a_stuck_clear: assert property (@(posedge clk) disable iff (!reset_n) // RL13
		txIn |=> !txStuck) else $error("stuck not cleared");
	// fault 4 lands in the low status half
	a_flag_f4: assert property (@(posedge clk) disable iff (!reset_n) // RL10
		faultSeen[F4_LOW_GND] |=> busErrorStatusLow[F4_LOW_GND]) else $error("f4 flag lost");
	// low-wire faults put single-wire reception on the high wire
	a_rx_high_sel: assert property (@(posedge clk) disable iff (!reset_n) // RL7
		(lowBad && modeEff == MODE_FULL) |=> rxOut == !$past(highDominant))
		else $error("rx not on high wire");
	// under-voltage never leaves a driver on
	a_uv_no_drive: assert property (@(posedge clk) disable iff (!reset_n) // RL16
		supplyLow |=> !highDriverEn && !lowDriverEn) else $error("uv drives");
endmodule : ftc_ctrl
`default_nettype wire

// ---- src/ftc_fifo.sv ----
// ftc_fifo: small synchronous FIFO with valid/ready on both sides
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module ftc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	// ==========================================================
	// storage and pointers
	logic [WIDTH-1:0] mem_q [DEPTH];               // entry array
	logic [AW-1:0]    wrPtr_q;                     // next write slot
	logic [AW-1:0]    rdPtr_q;                     // next read slot
	logic [AW:0]      count_q;                     // fill level
	wire              doWrite = inValid && inReady;
	wire              doRead  = outValid && outReady;
	assign inReady  = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];
	// write side: only the storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem_q[wrPtr_q] <= inData;
		end
	end
	// pointer and level bookkeeping
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doWrite) wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			if (doRead)  rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end
endmodule : ftc_fifo
`default_nettype wire

// ---- src/ftc_pkg.sv ----
// ftc_pkg: constants shared by the fault-tolerant transceiver control block
// assumes a 200 MHz device clock; filter counts are overridable at the top
package ftc_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_PS     = 5000;       // 200 MHz
	localparam int TX_STUCK_US       = 2000;       // 2.0 ms stuck-dominant limit
	localparam int TX_STUCK_CYCLES   = (TX_STUCK_US * 1000 * 1000) / CLK_PERIOD_PS;
	localparam int FILT_DEFAULT      = 1000;       // plain default filter count
	localparam int CNT_W             = 24;         // width of all filter counters
	// ==========================================================
	// fault numbering (bit index = fault number minus one)
	localparam int NUM_FAULTS        = 8;
	localparam int F1_HIGH_OPEN      = 0;
	localparam int F2_LOW_OPEN       = 1;
	localparam int F3_HIGH_BAT       = 2;
	localparam int F4_LOW_GND        = 3;
	localparam int F5_HIGH_GND       = 4;
	localparam int F6_LOW_BAT        = 5;
	localparam int F7_WIRES_SHORT    = 6;
	localparam int F8_HIGH_5V        = 7;
	localparam int STAT_HALF         = 4;          // flags per status register
	localparam int FIFO_DEPTH        = 8;
	// ==========================================================
	// receive path selection
	typedef enum logic [1:0] {
		RX_DIFF = 2'b00,                       // differential comparison
		RX_HIGH = 2'b01,                       // single wire on high wire
		RX_LOW  = 2'b10                        // single wire on low wire
	} ftc_rxsel_t;
	// transceiver operating modes
	typedef enum logic [1:0] {
		MODE_STANDBY   = 2'b00,
		MODE_FULL      = 2'b01,
		MODE_LISTEN    = 2'b10
	} ftc_mode_t;
endpackage : ftc_pkg
